/* hdl/isr_consts.vh */
// Constants for the four-instruction execute block.
// Assumes an opcode class field decoded upstream by the fetch stage.
`ifndef ISR_CONSTS_VH
`define ISR_CONSTS_VH
// Operation select codes
`define ISR_OP_NONE   3'h0
`define ISR_OP_INCSKP 3'h1
`define ISR_OP_ORREG  3'h2
`define ISR_OP_ORIMM  3'h3
`define ISR_OP_RDAUX  3'h4
// Field widths
`define ISR_DATA_W    8
`define ISR_RADDR_W   6
`define ISR_FADDR_W   4
// Reset values
`define ISR_WREG_RST  8'h00
`define ISR_ZERO_RST  1'b0
`define ISR_RADDR_RST 6'h00
`define ISR_FADDR_RST 4'h0
`define ISR_BYTE_RST  8'h00
`define ISR_VLD_RST   1'b0
`define ISR_DEST_RST  1'b0
`define ISR_WE_RST    1'b0
`define ISR_FLUSH_RST 1'b0
// Destination select: 0 accumulator, 1 register
`define ISR_DEST_REG  1'b1
`endif

/* hdl/isr_exec.v */
// Execute logic for increment-skip, register OR, immediate OR and aux page read.
// Assumes the register file and aux page answer reads combinationally in the same cycle.
// Assumes the fetch stage presents one decoded instruction per cycle at most, and that
// it honours flush_next_r by letting the slot taken while flush_next_r is high be dropped here.
`timescale 1ns/1ps
`include "isr_consts.vh"

// Notes on behaviour
// - Increment-skip adds one to the 6-bit addressed register and writes to accumulator (d=0) or register (d=1).
// - A zero increment result flushes the fetched next instruction, making it a two-cycle instruction.
// - Register OR writes accumulator OR register to accumulator or register by d, updates zero, one cycle.
// - Immediate OR writes accumulator OR 8-bit immediate to the accumulator, updates zero, one cycle.
// - Aux page read copies the 4-bit selected special register into the accumulator, one cycle.
module isr_exec #(
  // Data path width
  parameter DATA_W  = `ISR_DATA_W,
  // Register file address width
  parameter RADDR_W = `ISR_RADDR_W,
  // Aux page select width
  parameter FADDR_W = `ISR_FADDR_W
) (
  // Clock and reset
  input  wire               mclk,
  input  wire               reset,
  // Decoded instruction
  input  wire               instr_valid,
  input  wire [2:0]         instr_op,
  input  wire [RADDR_W-1:0] instr_raddr,
  input  wire [FADDR_W-1:0] instr_faddr,
  input  wire [DATA_W-1:0]  instr_imm,
  input  wire               instr_dest,
  // Register file read
  output reg  [RADDR_W-1:0] rf_raddr_r,
  input  wire [DATA_W-1:0]  rf_rdata,
  // Aux page read
  output reg  [FADDR_W-1:0] aux_raddr_r,
  input  wire [DATA_W-1:0]  aux_page_special_regs,
  // Register file write
  output reg                rf_we_r,
  output reg  [RADDR_W-1:0] rf_waddr_r,
  output reg  [DATA_W-1:0]  rf_wdata_r,
  // Core state
  output reg  [DATA_W-1:0]  working_register,
  output reg                zero_flag_r,
  output reg                flush_next_r
);

  // ==========================================================
  // Shared decoding
  // ==========================================================
  // One zero test serves both the skip decision and the zero flag,
  // so the two can never disagree about what counts as zero
  function is_null;
    input [DATA_W-1:0] value;
    begin
      is_null = (value == {DATA_W{1'b0}});
    end
  endfunction

  // Destination bit decode, shared by every op that may write back
  function dest_is_reg;
    input sel;
    begin
      dest_is_reg = (sel == `ISR_DEST_REG);
    end
  endfunction

  // ==========================================================
  // Read address capture
  // ==========================================================
  // Addresses are latched so the partner sees stable read addresses for the executing op
  // Operands of the slot under execution; a dropped slot keeps exec_r low,
  // so its stale operands are harmless
  reg              exec_r;
  reg [2:0]        op_r;
  reg [DATA_W-1:0] imm_r;
  reg              dest_r;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      exec_r      <= `ISR_VLD_RST;
      op_r        <= `ISR_OP_NONE;
      imm_r       <= {DATA_W{1'b0}};
      dest_r      <= `ISR_DEST_RST;
      rf_raddr_r  <= {RADDR_W{1'b0}};
      aux_raddr_r <= {FADDR_W{1'b0}};
    end else begin
      // drop flushed slot
      // A flushed slot executes as a no-operation
      exec_r      <= instr_valid & ~flush_next_r;
      op_r        <= instr_op;
      imm_r       <= instr_imm;
      dest_r      <= instr_dest;
      rf_raddr_r  <= instr_raddr;
      aux_raddr_r <= instr_faddr;
    end
  end

  // ==========================================================
  // Result computation
  // ==========================================================
  // The result is computed in the cycle after the slot is taken, while the
  // register file answers the latched read address
  reg [DATA_W-1:0] result_nxt;
  reg              to_reg_nxt;
  reg              upd_acc_nxt;
  reg              upd_zero_nxt;
  reg              skip_nxt;

  always @* begin
    result_nxt   = {DATA_W{1'b0}};
    to_reg_nxt   = 1'b0;
    upd_acc_nxt  = 1'b0;
    upd_zero_nxt = 1'b0;
    skip_nxt     = 1'b0;
    if (exec_r) begin
      case (op_r)
        `ISR_OP_INCSKP: begin
          // increment and route
          // Wraps from all ones to zero, which is what triggers the skip
          result_nxt  = rf_rdata + {{(DATA_W-1){1'b0}}, 1'b1};
          to_reg_nxt  = dest_is_reg(dest_r);
          upd_acc_nxt = ~to_reg_nxt;
          skip_nxt    = is_null(result_nxt);
        end
        `ISR_OP_ORREG: begin
          result_nxt   = working_register | rf_rdata;
          to_reg_nxt   = dest_is_reg(dest_r);
          upd_acc_nxt  = ~to_reg_nxt;
          upd_zero_nxt = 1'b1;
        end
        `ISR_OP_ORIMM: begin
          result_nxt   = working_register | imm_r;
          upd_acc_nxt  = 1'b1;
          upd_zero_nxt = 1'b1;
        end
        `ISR_OP_RDAUX: begin
          result_nxt  = aux_page_special_regs;
          upd_acc_nxt = 1'b1;
        end
        default: begin
          result_nxt = {DATA_W{1'b0}};
        end
      endcase
    end
  end

  // ==========================================================
  // State update
  // ==========================================================
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      working_register <= {DATA_W{1'b0}};
      zero_flag_r      <= `ISR_ZERO_RST;
      flush_next_r     <= `ISR_FLUSH_RST;
      rf_we_r          <= `ISR_WE_RST;
      rf_waddr_r       <= {RADDR_W{1'b0}};
      rf_wdata_r       <= {DATA_W{1'b0}};
    end else begin
      flush_next_r <= skip_nxt;
      rf_we_r      <= to_reg_nxt;
      rf_waddr_r   <= rf_raddr_r;
      rf_wdata_r   <= result_nxt;
      if (upd_acc_nxt) begin
        working_register <= result_nxt;
      end
      if (upd_zero_nxt) begin
        zero_flag_r <= is_null(result_nxt);
      end
    end
  end

endmodule // isr_exec

/* verification/isr_rf_model.sv */
// Register file and aux page partner for isr_exec, answering reads at once.
`timescale 1ns/1ps
module isr_rf_model (
  input  wire logic       mclk, rf_we_r,
  input  wire logic [5:0] rf_raddr_r, rf_waddr_r,
  input  wire logic [3:0] aux_raddr_r,
  input  wire logic [7:0] rf_wdata_r,
  output logic      [7:0] rf_rdata, aux_page_special_regs
);
  logic [7:0] mem [64];
  initial for (int i = 0; i < 64; i++) mem[i] = 8'hFF ^ 8'(i);
  assign rf_rdata = mem[rf_raddr_r];
  assign aux_page_special_regs = {aux_raddr_r, aux_raddr_r};
  always @(posedge mclk) if (rf_we_r) mem[rf_waddr_r] <= rf_wdata_r;
endmodule // isr_rf_model

/* verification/isr_chk.sv */
// Port checker for isr_exec, bound at the foot.
`timescale 1ns/1ps
module isr_chk (
  input wire logic       mclk, reset, instr_valid, instr_dest, zero_flag_r, flush_next_r, rf_we_r,
  input wire logic [2:0] instr_op,
  input wire logic [5:0] instr_raddr, rf_waddr_r,
  input wire logic [7:0] instr_imm, rf_rdata, aux_page_special_regs, rf_wdata_r, working_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire [4:0] t = {5{instr_valid & !flush_next_r}} & (5'h01 << instr_op);
  a_incr_sum: assert property (t[1] |=> ##1 ($past(instr_dest, 2) ? rf_wdata_r :
    working_register) == $past(rf_rdata) + 8'h01) else $error("incr sum");
  a_skip_flush: assert property (t[1] |=> ##1
    flush_next_r == ($past(rf_rdata) == 8'hFF)) else $error("skip flush");
  a_or_reg: assert property (t[2] && instr_dest |=> ##1
    rf_wdata_r == ($past(rf_rdata) | $past(working_register))) else $error("or reg");
  a_or_imm: assert property (t[3] |=> ##1
    working_register == ($past(working_register) | $past(instr_imm, 2))) else $error("or imm");
  a_aux_read: assert property (t[4] |=> ##1
    working_register == $past(aux_page_special_regs)) else $error("aux read");
  a_zero_imm: assert property (t[3] |=> ##1 zero_flag_r == !working_register)
    else $error("zero flag");
  a_wb_target: assert property ((t[1] || t[2]) |=> ##1 rf_we_r == $past(instr_dest, 2) &&
    (!rf_we_r || rf_waddr_r == $past(instr_raddr, 2))) else $error("writeback target");
  a_aux_nowrite: assert property (t[4] |=> ##1 !rf_we_r)
    else $error("aux read wrote");
endmodule // isr_chk
bind isr_exec isr_chk u_chk (.*);

/* verification/test_incr_skip_or_sfr_read_ops.sv */
// Bench: directed skips, then LFSR instructions issued two cycles apart.
`timescale 1ns/1ps
module test_incr_skip_or_sfr_read_ops;
  logic        mclk = 0, reset = 1, instr_valid = 0, instr_dest = 0, sk = 0, ez = 0;
  logic [2:0]  instr_op = 0;
  logic [5:0]  instr_raddr = 0, rf_raddr_r, rf_waddr_r;
  logic [3:0]  instr_faddr = 0, aux_raddr_r;
  logic [7:0]  instr_imm = 0, rf_rdata, aux_page_special_regs, rf_wdata_r, working_register;
  logic [7:0]  ea = 0, rf [64];
  logic        rf_we_r, zero_flag_r, flush_next_r;
  logic [1:0]  p = 0;
  logic [15:0] lf = 16'h4741;
  logic [10:0] e, q [$];
  int          n_errors = 0, comparisons = 0;
  wire  [10:0] seen = {flush_next_r, rf_we_r, working_register, zero_flag_r};
  always #2.5 mclk = ~mclk;
  isr_exec uut (.*);
  isr_rf_model m (.*);
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_sim;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic issue(logic [2:0] o, logic [5:0] a, logic [3:0] f, logic [7:0] i, logic d);
    logic [7:0] r;
    logic       fe, we;
    we = 0;
    r = o == 1 ? rf[a] + 8'h01 : rf[a] | ea;
    if (o == 3) r = ea | i;
    if (o == 4) r = {f, f};
    fe = o == 1 && !r && !sk;
    // A flushed slot changes nothing, whatever it holds
    if (!sk) begin
      if (o[1]) ez = !r;
      if (o > 2 || !d) ea = r;
      we = o < 3 && d;
    end
    if (we) rf[a] = r;
    sk = fe;
    q.push_back({fe, we, ea, ez});
    {instr_valid, instr_op, instr_raddr, instr_faddr, instr_imm, instr_dest} = {1'b1, o, a, f, i, d};
    @(posedge mclk);
    #1 instr_valid = 0;
    @(posedge mclk);
    #1;
  endtask
  task automatic check_result(input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (exp !== got) begin
      n_errors++;
      $display("ERROR result expected %h seen %h", exp, got);
    end
  endtask
  always @(negedge mclk) begin
    p <= {p[0], instr_valid};
    if (p[1]) begin
      e = q.pop_front();
      check_result(e, seen);
    end
  end
  initial begin
    for (int k = 0; k < 64; k++) rf[k] = 8'hFF ^ 8'(k);
    repeat (12) @(posedge mclk);
    #1 reset = 0;
    issue(1, 0, 0, 8'h00, 0);
    issue(3, 0, 0, 8'h40, 0);
    issue(3, 0, 0, 8'h00, 0);
    issue(1, 0, 0, 8'h00, 1);
    issue(4, 0, 3, 8'h00, 0);
    $display("directed test done");
    repeat (40) begin
      lf = nx(lf);
      issue(3'(lf[1:0]) + 3'h1, lf[7:2], lf[11:8], lf[15:8], lf[12]);
    end
    $display("random test done");
    repeat (4) @(posedge mclk);
    end_sim;
  end
  initial begin
    #5000;
    n_errors++;
    end_sim;
  end
endmodule // test_incr_skip_or_sfr_read_ops
